// ===== event_status_map.svh
// Offsets-free constants for the event status block: field positions and resets.
`ifndef EVENT_STATUS_MAP_SVH
`define EVENT_STATUS_MAP_SVH
`define STD_BIT_OPC 0
`define STD_BIT_QYE 2
`define STD_BIT_DDE 3
`define STD_BIT_EXE 4
`define STD_BIT_CME 5
`define STD_BIT_PON 7
`define STD_USED_MASK 8'hbd
`define STD_RESET 8'h80
`define ERR_BIT_EXTCLK 0
`define ERR_BIT_UNCALIBRATED_LEVEL 1
`define ERR_BIT_RPP 2
`define ERR_BIT_PLL 3
`define ERR_BIT_DOWNLOAD 5
`define ERR_USED_MASK 8'h2f
`define END_BIT_FREQ 0
`define END_BIT_CAL 1
`define END_BIT_LEVEL 2
`define END_BIT_SWEEP 4
`define END_BIT_DOWNLOAD 5
`define END_USED_MASK 8'h37
`define MASK_RESET 8'h00
`define STB_BIT_END 2
`define STB_BIT_ERR 3
`define STB_BIT_ESB 5
`endif

// ===== event_status_pkg.sv
// Types shared by the event status block.
package event_status_pkg;
   typedef logic [7:0] byte_t;
   // Command strobes decoded by the message parser, one cycle each.
   typedef struct packed {
      logic clear_status;
      logic std_query;
      logic std_mask_set;
      logic std_mask_query;
      logic ext_query_a;
      logic ext_query_b;
      logic ext_mask_set_a;
      logic ext_mask_set_b;
      logic ext_mask_query_a;
      logic ext_mask_query_b;
   } cmd_s;
   typedef enum logic [2:0] {
      SEL_STD = 3'b000,
      SEL_STD_MASK = 3'b001,
      SEL_ERR = 3'b010,
      SEL_END = 3'b011,
      SEL_ERR_MASK = 3'b100,
      SEL_END_MASK = 3'b101
   } sel_e;
endpackage

// ===== event_status_registers.sv
// Event status registers with enable masks and status byte summaries.
//
// Behaviour
// - Set standard bit 7 on power-on.
// - Set standard bit 5 on a command error.
// - Set standard bit 4 on an execution error.
// - Set standard bit 3 on a device-dependent error.
// - Set standard bit 2 on a query error.
// - Set standard bit 0 when operation-complete command is processed.
// - An event bit feeds its summary only when its enable bit is set.
// - Standard event query returns the register then clears it.
// - No external writes to the standard event register except clearing.
// - Power-on loads 0x80; clear-status zeroes the standard register.
// - Standard mask is readable by query and writable by its set command.
// - Standard mask clears at power-on or when set with zero.
// - Standard mask unchanged by device clear, reset and clear-status.
// - Completion summary on status bit 2, error summary on bit 3.
// - Error bit 5 on download failure.
// - Error bit 3 on phase-locked-loop unlock.
// - Error bit 2 on reverse power relay trip.
// - Error bit 1 when output level becomes uncalibrated.
// - Error bit 0 when external modulation clock stops being valid.
// - Completion bits 5,4,2,1,0: download, sweep, level, calibration, frequency.
// - Extended event query returns the register then clears it.
// - Extended registers: no writes; cleared by clear-status, power-on, query.
// - Status bit 5 high exactly when any enabled standard bit set; here a mask write reaches bit 5 one cycle late.
// - Extended masks clear at power-on or zero set; else keep value.
`timescale 1ns/100ps
`include "event_status_map.svh"
module event_status_registers
   import event_status_pkg::*;
(
   input wire logic CORE_CLK, // System clock, 100 MHz.
   input wire logic SYS_RST, // Synchronous power-on reset.
   input wire logic CMD_ERR, // Command error pulse.
   input wire logic EXEC_ERR, // Execution error pulse.
   input wire logic DEV_ERR, // Device-dependent error pulse.
   input wire logic QUERY_ERR, // Query error pulse.
   input wire logic OPC_DONE, // Operation-complete processed pulse.
   input wire logic DOWNLOAD_FAIL, // Download failure, from pin.
   input wire logic PLL_UNLOCK, // Unlock detect, from pin.
   input wire logic REVERSE_POWER_TRIP, // Relay trip, from pin.
   input wire logic UNCALIBRATED_LEVEL, // Level uncalibrated_level, from pin.
   input wire logic EXT_CLK_LOST, // External clock invalid, from pin.
   input wire logic DOWNLOAD_DONE, // Download end pulse.
   input wire logic SWEEP_DONE, // Sweep end pulse.
   input wire logic LEVEL_SET_DONE, // Level setting end pulse.
   input wire logic CAL_DONE, // Level calibration end pulse.
   input wire logic FREQUENCY_SETTING_DONE, // Frequency setting end pulse.
   input wire cmd_s CMD, // Decoded command strobes.
   input wire byte_t CMD_DATA, // Data for mask set commands.
   output logic [7:0] RESP_DATA, // Query answer, binary weighted.
   output logic RESP_VALID, // Answer strobe, one cycle.
   output logic [7:0] STB_SUMMARY // Summary bits 2, 3 and 5 of status byte.
);

   byte_t std_reg, std_next, std_mask_reg;
   byte_t err_reg, err_next, err_mask_reg;
   byte_t end_reg, end_next, end_mask_reg;
   byte_t std_set, err_set, end_set;
   logic [4:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic [4:0] pin_rise;
   logic resp_pending;

   // Two-stage synchroniser for the asynchronous error sources.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
         pin_prev_reg <= 5'h00;
      end else begin
         pin_meta_reg <= {DOWNLOAD_FAIL, PLL_UNLOCK, REVERSE_POWER_TRIP,
                          UNCALIBRATED_LEVEL, EXT_CLK_LOST};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // Errors are events: only the entry into the condition sets a bit.
   assign pin_rise = pin_sync_reg & ~pin_prev_reg;

   // Set vectors; unused positions stay zero.
   always_comb begin
      std_set = 8'h00;
      std_set[`STD_BIT_CME] = CMD_ERR;
      std_set[`STD_BIT_EXE] = EXEC_ERR;
      std_set[`STD_BIT_DDE] = DEV_ERR;
      std_set[`STD_BIT_QYE] = QUERY_ERR;
      std_set[`STD_BIT_OPC] = OPC_DONE;
      err_set = 8'h00;
      err_set[`ERR_BIT_DOWNLOAD] = pin_rise[4];
      err_set[`ERR_BIT_PLL] = pin_rise[3];
      err_set[`ERR_BIT_RPP] = pin_rise[2];
      err_set[`ERR_BIT_UNCALIBRATED_LEVEL] = pin_rise[1];
      err_set[`ERR_BIT_EXTCLK] = pin_rise[0];
      end_set = 8'h00;
      end_set[`END_BIT_DOWNLOAD] = DOWNLOAD_DONE;
      end_set[`END_BIT_SWEEP] = SWEEP_DONE;
      end_set[`END_BIT_LEVEL] = LEVEL_SET_DONE;
      end_set[`END_BIT_CAL] = CAL_DONE;
      end_set[`END_BIT_FREQ] = FREQUENCY_SETTING_DONE;
   end

   // Next event values: clears by query or clear-status, a new event wins.
   always_comb begin
      std_next = std_reg;
      if (CMD.clear_status || CMD.std_query) begin
         std_next = 8'h00;
      end
      std_next = (std_next | std_set) & `STD_USED_MASK;
      err_next = err_reg;
      if (CMD.clear_status || CMD.ext_query_a) begin
         err_next = 8'h00;
      end
      err_next = (err_next | err_set) & `ERR_USED_MASK;
      end_next = end_reg;
      if (CMD.clear_status || CMD.ext_query_b) begin
         end_next = 8'h00;
      end
      end_next = (end_next | end_set) & `END_USED_MASK;
   end

   // Event registers; power-on leaves only the power-on bit set.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         std_reg <= `STD_RESET;
         err_reg <= 8'h00;
         end_reg <= 8'h00;
      end else begin
         std_reg <= std_next;
         err_reg <= err_next;
         end_reg <= end_next;
      end
   end

   // Enable masks; clear-status does not touch them, zero data clears.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         std_mask_reg <= `MASK_RESET;
         err_mask_reg <= `MASK_RESET;
         end_mask_reg <= `MASK_RESET;
      end else begin
         if (CMD.std_mask_set) begin
            std_mask_reg <= CMD_DATA;
         end
         if (CMD.ext_mask_set_a) begin
            err_mask_reg <= CMD_DATA;
         end
         if (CMD.ext_mask_set_b) begin
            end_mask_reg <= CMD_DATA;
         end
      end
   end

   // Query answers return the value held before the read clears it.
   assign resp_pending = CMD.std_query | CMD.std_mask_query |
                         CMD.ext_query_a | CMD.ext_query_b |
                         CMD.ext_mask_query_a | CMD.ext_mask_query_b;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         RESP_DATA <= 8'h00;
         RESP_VALID <= 1'b0;
      end else begin
         RESP_VALID <= resp_pending;
         if (CMD.std_query) begin
            RESP_DATA <= std_reg;
         end else if (CMD.std_mask_query) begin
            RESP_DATA <= std_mask_reg;
         end else if (CMD.ext_query_a) begin
            RESP_DATA <= err_reg;
         end else if (CMD.ext_query_b) begin
            RESP_DATA <= end_reg;
         end else if (CMD.ext_mask_query_a) begin
            RESP_DATA <= err_mask_reg;
         end else if (CMD.ext_mask_query_b) begin
            RESP_DATA <= end_mask_reg;
         end
      end
   end

   // Summary bits follow the new event values and the mask values held before any write.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         STB_SUMMARY <= 8'h00;
      end else begin
         STB_SUMMARY <= 8'h00;
         STB_SUMMARY[`STB_BIT_ESB] <= |(std_next & std_mask_reg);
         STB_SUMMARY[`STB_BIT_ERR] <= |(err_next & err_mask_reg);
         STB_SUMMARY[`STB_BIT_END] <= |(end_next & end_mask_reg);
      end
   end

   // Assertions.
   property p_pon;
      @(posedge CORE_CLK) $fell(SYS_RST) |-> std_reg[`STD_BIT_PON];
   endproperty
   a_pon: assert property (p_pon) else $error("power-on bit not set");

   property p_cme;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD_ERR |=> std_reg[`STD_BIT_CME];
   endproperty
   a_cme: assert property (p_cme) else $error("command error lost");

   property p_opc;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         OPC_DONE |=> std_reg[`STD_BIT_OPC];
   endproperty
   a_opc: assert property (p_opc) else $error("opc bit lost");

   property p_exe;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         EXEC_ERR |=> std_reg[`STD_BIT_EXE];
   endproperty
   a_exe: assert property (p_exe) else $error("execution error lost");

   property p_dde;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         DEV_ERR |=> std_reg[`STD_BIT_DDE];
   endproperty
   a_dde: assert property (p_dde) else $error("device error lost");

   property p_qye;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         QUERY_ERR |=> std_reg[`STD_BIT_QYE];
   endproperty
   a_qye: assert property (p_qye) else $error("query error lost");

   property p_cls_std;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.clear_status && !(|std_set) |=> std_reg == 8'h00;
   endproperty
   a_cls_std: assert property (p_cls_std)
      else $error("standard flags not cleared");

   property p_mask_set;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.std_mask_set |=> std_mask_reg == $past(CMD_DATA);
   endproperty
   a_mask_set: assert property (p_mask_set)
      else $error("standard mask not written");

   property p_mask_query;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.std_mask_query && !CMD.std_query |=>
            RESP_VALID && RESP_DATA == $past(std_mask_reg);
   endproperty
   a_mask_query: assert property (p_mask_query)
      else $error("standard mask query wrong");

   property p_err_sum;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         ##1 STB_SUMMARY[`STB_BIT_ERR] == |(err_reg & $past(err_mask_reg));
   endproperty
   a_err_sum: assert property (p_err_sum)
      else $error("error summary mismatch");

   property p_end_sum;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         ##1 STB_SUMMARY[`STB_BIT_END] == |(end_reg & $past(end_mask_reg));
   endproperty
   a_end_sum: assert property (p_end_sum)
      else $error("completion summary mismatch");

   property p_dl_fail;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         $rose(pin_sync_reg[4]) |=> err_reg[`ERR_BIT_DOWNLOAD];
   endproperty
   a_dl_fail: assert property (p_dl_fail)
      else $error("download failure not latched");

   property p_rpp;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         $rose(pin_sync_reg[2]) |=> err_reg[`ERR_BIT_RPP];
   endproperty
   a_rpp: assert property (p_rpp) else $error("relay trip not latched");

   property p_uncalibrated_level;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         $rose(pin_sync_reg[1]) |=> err_reg[`ERR_BIT_UNCALIBRATED_LEVEL];
   endproperty
   a_uncalibrated_level: assert property (p_uncalibrated_level)
      else $error("uncalibrated level not latched");

   property p_extclk;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         $rose(pin_sync_reg[0]) |=> err_reg[`ERR_BIT_EXTCLK];
   endproperty
   a_extclk: assert property (p_extclk)
      else $error("clock loss not latched");

   property p_sweep;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         SWEEP_DONE |=> end_reg[`END_BIT_SWEEP];
   endproperty
   a_sweep: assert property (p_sweep) else $error("sweep end lost");

   property p_err_query;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.ext_query_a && !(|err_set) |=> err_reg == 8'h00;
   endproperty
   a_err_query: assert property (p_err_query)
      else $error("error flags not cleared");

   property p_cls_ext;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.clear_status && !(|err_set) && !(|end_set) |=>
            err_reg == 8'h00 && end_reg == 8'h00;
   endproperty
   a_cls_ext: assert property (p_cls_ext)
      else $error("extended flags not cleared");

   property p_ext_mask;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.ext_mask_set_a |=> err_mask_reg == $past(CMD_DATA);
   endproperty
   a_ext_mask: assert property (p_ext_mask)
      else $error("error mask not written");

   property p_ext_mask_hold;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.clear_status && !CMD.ext_mask_set_b |=> $stable(end_mask_reg);
   endproperty
   a_ext_mask_hold: assert property (p_ext_mask_hold)
      else $error("completion mask changed by clear");

   property p_std_query;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.std_query && !(|std_set) |=>
            RESP_VALID && RESP_DATA == $past(std_reg) && std_reg == 8'h00;
   endproperty
   a_std_query: assert property (p_std_query)
      else $error("standard query wrong");

   property p_cls_mask;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.clear_status && !CMD.std_mask_set |=> $stable(std_mask_reg);
   endproperty
   a_cls_mask: assert property (p_cls_mask)
      else $error("mask changed by clear");

   property p_esb;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         ##1 STB_SUMMARY[`STB_BIT_ESB] == |(std_reg & $past(std_mask_reg));
   endproperty
   a_esb: assert property (p_esb) else $error("summary mismatch");

   property p_pll;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         $rose(pin_sync_reg[3]) |=> err_reg[`ERR_BIT_PLL];
   endproperty
   a_pll: assert property (p_pll) else $error("unlock not latched");

   property p_ext_query;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.ext_query_b && !(|end_set) |=> end_reg == 8'h00;
   endproperty
   a_ext_query: assert property (p_ext_query)
      else $error("completion not cleared");

   property p_unused;
      @(posedge CORE_CLK)
         (std_reg & ~`STD_USED_MASK) == 8'h00 &&
         (err_reg & ~`ERR_USED_MASK) == 8'h00 &&
         (end_reg & ~`END_USED_MASK) == 8'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");

   property p_cv_query;
      @(posedge CORE_CLK) disable iff (SYS_RST) CMD.std_query ##1 RESP_VALID;
   endproperty
   c_cv_query: cover property (p_cv_query);

   property p_cv_err;
      @(posedge CORE_CLK) disable iff (SYS_RST) STB_SUMMARY[`STB_BIT_ERR];
   endproperty
   c_cv_err: cover property (p_cv_err);

   property p_cv_race;
      @(posedge CORE_CLK) disable iff (SYS_RST) CMD.clear_status && CMD_ERR;
   endproperty
   c_cv_race: cover property (p_cv_race);

   property p_cv_mask_zero;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         CMD.std_mask_set && CMD_DATA == 8'h00;
   endproperty
   c_cv_mask_zero: cover property (p_cv_mask_zero);

endmodule

// ===== remote_controller.sv
// Model of the external controller that issues decoded commands.
`timescale 1ns/100ps
module remote_controller
   import event_status_pkg::*;
(
   input wire logic CORE_CLK, // System clock.
   output cmd_s CMD, // Command strobes toward the device.
   output byte_t CMD_DATA // Mask data toward the device.
);
   // Idle state: no strobe, and the data line holds no useful value.
   initial begin
      CMD = '0;
      CMD_DATA = 8'h5a;
   end
   // Issues one strobe for one cycle, then inverts the data line.
   task automatic issue(input int k, input byte_t d);
      @(negedge CORE_CLK);
      CMD = cmd_s'(10'h001 << k);
      CMD_DATA = d;
      @(negedge CORE_CLK);
      CMD = '0;
      CMD_DATA = ~d;
   endtask
endmodule

// ===== tb_event_status_registers.sv
// Self-checking bench for the event status registers.
`timescale 1ns/100ps
module tb_event_status_registers
   import event_status_pkg::*;
;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [4:0] ev = '0;
   logic [4:0] cp = '0;
   logic [4:0] pins = '0;
   cmd_s cmd;
   byte_t cmd_data;
   logic [7:0] resp_data;
   logic resp_valid;
   logic [7:0] stb;
   int std_m = 8'h80, msk_m = 0, err_m = 0, end_m = 0, ma_m = 0, mb_m = 0;
   int errors = 0, checked = 0, seed = 12;
   // Free-running clock at 100 MHz.
   always #5 CORE_CLK = ~CORE_CLK;
   // Device under test.
   event_status_registers u_event_status_registers (
      .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CMD_ERR(ev[4]),
      .EXEC_ERR(ev[3]), .DEV_ERR(ev[2]), .QUERY_ERR(ev[1]),
      .OPC_DONE(ev[0]), .DOWNLOAD_FAIL(pins[4]), .PLL_UNLOCK(pins[3]),
      .REVERSE_POWER_TRIP(pins[2]), .UNCALIBRATED_LEVEL(pins[1]),
      .EXT_CLK_LOST(pins[0]), .DOWNLOAD_DONE(cp[4]), .SWEEP_DONE(cp[3]),
      .LEVEL_SET_DONE(cp[2]), .CAL_DONE(cp[1]),
      .FREQUENCY_SETTING_DONE(cp[0]), .CMD(cmd), .CMD_DATA(cmd_data),
      .RESP_DATA(resp_data), .RESP_VALID(resp_valid), .STB_SUMMARY(stb));
   // Controller model on the command side.
   remote_controller u_remote_controller (
      .CORE_CLK(CORE_CLK), .CMD(cmd), .CMD_DATA(cmd_data));
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Compares one value with its expectation.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Issues a query and compares the answer under a bounded wait.
   task automatic query(input int k, input int exp);
      int n;
      u_remote_controller.issue(k, 8'h00);
      n = 0;
      while (resp_valid !== 1'b1 && n < 4) begin
         @(posedge CORE_CLK);
         #1;
         n++;
      end
      if (resp_valid !== 1'b1) begin
         errors++;
         summarize();
      end
      check(resp_data, 8'(exp));
   endtask
   // Main sequence: random events, mask writes, clears and queries.
   initial begin
      int i, m, d;
      repeat (8) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      SYS_RST = 1'b0;
      for (i = 0; i < 40; i++) begin
         @(negedge CORE_CLK);
         ev = 5'($random(seed));
         cp = 5'($random(seed));
         pins = 5'($random(seed));
         @(negedge CORE_CLK);
         ev = '0;
         cp = '0;
         repeat (6) @(negedge CORE_CLK);
         m = {$random(seed)} % 4;
         d = ({$random(seed)} % 3 == 0) ? 0 : {$random(seed)} % 256;
         if (m == 3) begin
            u_remote_controller.issue(9, 8'(d));
            std_m = 0;
            err_m = 0;
            end_m = 0;
         end else begin
            u_remote_controller.issue((m == 0) ? 7 : (m == 1) ? 3 : 2,
               8'(d));
            if (m == 0) msk_m = d;
            else if (m == 1) ma_m = d;
            else mb_m = d;
         end
         repeat (3) @(negedge CORE_CLK);
         check(stb, {2'b0, (std_m & msk_m) != 0, 1'b0, (err_m & ma_m) != 0,
            (end_m & mb_m) != 0, 2'b0});
         query(8, std_m);
         query(6, msk_m);
         query(5, err_m);
         query(4, end_m);
         query(1, ma_m);
         query(0, mb_m);
         std_m = 0;
         err_m = 0;
         end_m = 0;
      end
      summarize();
   end
   // Event bookkeeping of the model, sampled when pulses are applied.
   always @(posedge CORE_CLK) begin
      if (!SYS_RST) begin
         std_m |= {2'b0, ev[4], ev[3], ev[2], ev[1], 1'b0, ev[0]};
         end_m |= {2'b0, cp[4], cp[3], 1'b0, cp[2], cp[1], cp[0]};
      end
   end
   // Rising pin levels set error flags once they have settled.
   logic [4:0] pins_old = '0;
   always @(negedge CORE_CLK) begin
      if (pins !== pins_old && cmd === '0) begin
         err_m |= {2'b0, pins[4] & ~pins_old[4], 1'b0,
            pins[3:0] & ~pins_old[3:0]};
         pins_old = pins;
      end
   end
endmodule
